/* modem_ctl_pkg.sv */
// Shared constants, register map and types for the modem control lines block
package modem_ctl_pkg;

    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned WAKE_TIME_US  = 5_000;
    localparam int unsigned RING_TIME_MS  = 1_000;
    localparam int unsigned WAKE_CYCLES   = (CLK_HZ / 1_000_000) * WAKE_TIME_US;
    localparam int unsigned RING_CYCLES   = (CLK_HZ / 1_000) * RING_TIME_MS;
    localparam int unsigned CHAR_GUARD    = 2;

    // Register byte addresses on the bus
    localparam logic [3:0] CTRL_ADDR   = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [3:0] EVENT_ADDR  = 4'h8;

    // Control register field positions
    localparam int unsigned CTRL_HWFC_BIT  = 0;
    localparam int unsigned CTRL_DSRTR_BIT = 1;
    localparam int unsigned CTRL_DCDTR_BIT = 2;
    localparam int unsigned CTRL_RINGE_BIT = 3;
    localparam int unsigned CTRL_PSAVE_LSB = 4;
    localparam int unsigned CTRL_MODE_LSB  = 6;

    // Event register (write one to fire) bit positions
    localparam int unsigned EV_MSG_BIT     = 0;
    localparam int unsigned EV_CARR_ON     = 1;
    localparam int unsigned EV_CARR_OFF    = 2;
    localparam int unsigned EV_CALL_UP     = 3;
    localparam int unsigned EV_CALL_DOWN   = 4;
    localparam int unsigned EV_MSGCMD_BEG  = 5;
    localparam int unsigned EV_MSGCMD_END  = 6;

    localparam logic [1:0] PSAVE_OFF   = 2'h0;
    localparam logic [1:0] PSAVE_CYCLE = 2'h1;
    localparam logic [1:0] PSAVE_RTS   = 2'h2;
    localparam logic [1:0] PSAVE_DTR   = 2'h3;

    localparam logic [7:0] CTRL_RESET  = 8'h0f;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // Interface modes, Gray coded along command -> data -> online command
    typedef enum logic [1:0] {
        MODE_CMD    = 2'b00,
        MODE_DATA   = 2'b01,
        MODE_ONLINE = 2'b11
    } if_mode_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] power_save_setting;
        logic       ring_enable;
        logic       dcd_track;
        logic       dsr_track;
        logic       hw_flow;
    } ctrl_t;

    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } bus_req_t;

    typedef struct packed {
        logic dsr_n;
        logic dcd_n;
        logic ri_n;
    } modem_out_t;

endpackage

/* pulse_timer.sv */
// Retriggerable one-shot timer counting clock cycles
`timescale 1ns/1ns
module pulse_timer
    import modem_ctl_pkg::*;
#(
    parameter int unsigned CYCLES = 1000
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic trigger,
    output logic      active
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES);
    localparam logic [W-1:0] ONE  = W'(1);

    logic [W-1:0] count_reg;
    wire  logic   running = (count_reg != '0);

    // Every trigger reloads the full interval, so pulses merge
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_reg <= '0;
        end else if (trigger) begin
            count_reg <= LOAD;
        end else if (running) begin
            count_reg <= count_reg - ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            active <= 1'b0;
        end else begin
            active <= trigger || (count_reg > ONE);
        end
    end
endmodule

/* modem_ctl.sv */
// Modem control lines: RTS flow control, RTS/DTR wake-up, DSR, DCD and RI outputs
//
// Overview of operation
// RL1: RTS reads OFF at init and when undriven, via pull-up.
// RL2: With flow control on, transmit pauses while RTS is OFF.
// RL3: Transmit stops within two characters of RTS going OFF.
// RL4: Power-save 2, flow control off: RTS OFF disables port, allows idle.
// RL5: Power-save 2: RTS rising to ON wakes port, ready after 5 ms.
// RL6: Power-save 3: DTR OFF disables port and allows idle.
// RL7: Power-save 3: DTR rising to ON wakes port, ready after 5 ms.
// RL8: DTR reads OFF at init and when undriven, via pull-up.
// RL9: DSR tracking: OFF at init and command modes, ON in data mode.
// RL10: Without DSR tracking, DSR is ON permanently from init.
// RL11: DCD tracking: OFF at init, then follows carrier detect.
// RL12: Packet dial enters data mode and raises DCD before connect.
// RL13: DCD stays ON in online command mode; DSR driven separately.
// RL14: Call released during message command keeps DCD until it completes; held here only for a release in online command mode.
// RL15: Without carrier tracking, DCD is ON permanently from init.
// RL16: RI OFF at init; each message arrival pulses RI ON 1 s.
// RL17: Close message arrivals retrigger RI without dropping it.
// RL18: Host must not count RI pulses; it queries the device.
// RL19: RI pulse timed by own counter, restarted by each event.
// RL20: RTS and DTR synchronised before edge or level use.
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
module modem_ctl
    import modem_ctl_pkg::*;
#(
    parameter int unsigned WAKE_CNT = WAKE_CYCLES,
    parameter int unsigned RING_CNT = RING_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Host-side lines, low is ON
    input  wire logic        rts_n_in,
    input  wire logic        rts_n_driven,
    input  wire logic        dtr_n_in,
    input  wire logic        dtr_n_driven,
    output logic             dsr_n,
    output logic             dcd_n,
    output logic             ri_n,
    // Transmit side towards the host
    input  wire logic        tx_char_done,
    output logic             tx_allow,
    // Power control
    output logic             port_enable,
    output logic             force_active,
    output logic             idle_allow,
    output logic             rx_ready
);
    localparam int unsigned WW = $clog2(WAKE_CNT + 1);
    localparam logic [WW-1:0] WAKE_LOAD = WW'(WAKE_CNT);
    localparam logic [WW-1:0] WAKE_ONE  = WW'(1);
    localparam logic [1:0]    GUARD     = 2'(CHAR_GUARD);

    bus_req_t req;
    assign req = '{address: avs_address, read: avs_read, write: avs_write,
                   writedata: avs_writedata};

    // Undriven pins read OFF, as the internal pull-up would leave them
    wire logic rts_pin = rts_n_driven ? rts_n_in : 1'b1;  // see RL1
    wire logic dtr_pin = dtr_n_driven ? dtr_n_in : 1'b1;  // see RL8

    // Two-stage synchronisers, preset OFF
    logic rts_meta_reg, rts_sync_reg, rts_prev_reg;
    logic dtr_meta_reg, dtr_sync_reg, dtr_prev_reg;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rts_meta_reg <= 1'b1;
            rts_sync_reg <= 1'b1;
            rts_prev_reg <= 1'b1;
            dtr_meta_reg <= 1'b1;
            dtr_sync_reg <= 1'b1;
            dtr_prev_reg <= 1'b1;
        end else begin
            rts_meta_reg <= rts_pin;       // see RL20
            rts_sync_reg <= rts_meta_reg;
            rts_prev_reg <= rts_sync_reg;
            dtr_meta_reg <= dtr_pin;       // see RL20
            dtr_sync_reg <= dtr_meta_reg;
            dtr_prev_reg <= dtr_sync_reg;
        end
    end

    wire logic rts_on   = !rts_sync_reg;
    wire logic dtr_on   = !dtr_sync_reg;
    wire logic rts_rise = rts_prev_reg && !rts_sync_reg;
    wire logic dtr_rise = dtr_prev_reg && !dtr_sync_reg;

    // Register file
    ctrl_t ctrl_reg;
    logic  carrier_reg, call_reg, msgcmd_reg;

    wire logic sel_ctrl   = (req.address[3:0] == CTRL_ADDR);
    wire logic sel_status = (req.address[3:0] == STATUS_ADDR);
    wire logic sel_event  = (req.address[3:0] == EVENT_ADDR);
    wire logic mapped     = (req.address[7:4] == 4'h0) &&
                            (sel_ctrl || sel_status || sel_event);

    // One wait cycle: request accepted when waitrequest has dropped
    logic  ack_reg;
    wire logic access = (req.read || req.write) && !ack_reg;
    // Writes land at the edge where the master sees waitrequest low
    wire logic wr_go  = req.write && ack_reg && mapped;
    wire logic [31:0] ev = (wr_go && sel_event) ? req.writedata : 32'h0000_0000;

    wire logic msg_event = ev[EV_MSG_BIT];
    wire logic dial_cmd  = ev[EV_CALL_UP];

    // Interface mode: dial enters data mode; leaving it keeps the call
    if_mode_t  mode_cur;
    assign mode_cur = if_mode_t'(ctrl_reg.mode);

    ctrl_t ctrl_next;
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_go && sel_ctrl) begin
            ctrl_next = ctrl_t'(req.writedata[7:0]);
        end
        if (dial_cmd) begin
            ctrl_next.mode = MODE_DATA;  // see RL12
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_reg <= ctrl_t'(CTRL_RESET);
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Call, carrier and message-command state; sets win over clears
    wire logic call_next   = ev[EV_CALL_UP] || (call_reg && !ev[EV_CALL_DOWN]);
    wire logic carr_next   = ev[EV_CARR_ON] || (carrier_reg && !ev[EV_CARR_OFF]);
    wire logic msgcmd_next = ev[EV_MSGCMD_BEG] || (msgcmd_reg && !ev[EV_MSGCMD_END]);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            call_reg    <= 1'b0;
            carrier_reg <= 1'b0;
            msgcmd_reg  <= 1'b0;
        end else begin
            call_reg    <= call_next;
            carrier_reg <= carr_next;
            msgcmd_reg  <= msgcmd_next;
        end
    end

    // Hold DCD through a message command that straddles a call release in online command mode
    logic dcd_hold_reg;
    wire  logic dcd_hold_next = msgcmd_next && (dcd_hold_reg ||
                                (call_reg && !call_next && mode_cur == MODE_ONLINE));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dcd_hold_reg <= 1'b0;
        end else begin
            dcd_hold_next_q: dcd_hold_reg <= dcd_hold_next;  // see RL14
        end
    end

    // Output line levels, low is ON
    wire logic dsr_on_next = !ctrl_reg.dsr_track ||
                             (mode_cur == MODE_DATA);                     // see RL9, RL10
    wire logic dcd_on_next = !ctrl_reg.dcd_track || carrier_reg ||
                             (call_reg && mode_cur != MODE_CMD) ||        // see RL12, RL13
                             dcd_hold_reg;                                // see RL11, RL15

    // Ring indicate pulse timer
    logic ring_active;
    pulse_timer #(
        .CYCLES (RING_CNT)
    ) ring_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .trigger (msg_event && ctrl_reg.ring_enable),  // see RL16, RL17, RL19
        .active  (ring_active)
    );

    modem_out_t lines_reg;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lines_reg <= '{dsr_n: 1'b1, dcd_n: 1'b1, ri_n: 1'b1};  // see RL9, RL11, RL16
        end else begin
            lines_reg <= '{dsr_n: !dsr_on_next, dcd_n: !dcd_on_next,
                           ri_n: !ring_active};
        end
    end
    assign dsr_n = lines_reg.dsr_n;
    assign dcd_n = lines_reg.dcd_n;
    assign ri_n  = lines_reg.ri_n;

    // Flow control: stop at the current character boundary, at most two late
    logic       tx_allow_reg;
    logic [1:0] guard_reg;
    wire  logic flow_stop = ctrl_reg.hw_flow && !rts_on;  // see RL2

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tx_allow_reg <= 1'b1;
            guard_reg    <= 2'h0;
        end else if (!flow_stop) begin
            tx_allow_reg <= 1'b1;
            guard_reg    <= 2'h0;
        end else begin
            tx_allow_reg <= 1'b0;  // see RL3
            if (tx_char_done && guard_reg != GUARD) begin
                guard_reg <= guard_reg + 2'h1;
            end
        end
    end
    assign tx_allow = tx_allow_reg;

    // Line-controlled power save
    wire logic rts_ctl  = (ctrl_reg.power_save_setting == PSAVE_RTS) &&
                          !ctrl_reg.hw_flow;                         // see RL4
    wire logic dtr_ctl  = (ctrl_reg.power_save_setting == PSAVE_DTR); // see RL6
    wire logic ctl_on   = rts_ctl ? rts_on : dtr_on;
    wire logic ctl_rise = rts_ctl ? rts_rise : dtr_rise;
    wire logic line_ctl = rts_ctl || dtr_ctl;
    wire logic psave_on = ctrl_reg.power_save_setting != PSAVE_OFF;

    logic [WW-1:0] wake_reg;
    logic          port_en_reg, force_reg, idle_reg, rx_ready_reg;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wake_reg <= '0;
        end else if (line_ctl && ctl_rise) begin
            wake_reg <= WAKE_LOAD;  // see RL5, RL7
        end else if (!line_ctl || !ctl_on) begin
            wake_reg <= '0;
        end else if (wake_reg != '0) begin
            wake_reg <= wake_reg - WAKE_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            port_en_reg  <= 1'b1;
            force_reg    <= 1'b0;
            idle_reg     <= 1'b0;
            rx_ready_reg <= 1'b1;
        end else if (line_ctl) begin
            port_en_reg  <= ctl_on;                          // see RL4, RL6
            force_reg    <= ctl_on;                          // see RL5, RL7
            idle_reg     <= !ctl_on;                         // see RL4, RL6
            rx_ready_reg <= ctl_on && (wake_reg <= WAKE_ONE) && !ctl_rise;
        end else begin
            port_en_reg  <= 1'b1;
            force_reg    <= 1'b0;
            idle_reg     <= psave_on;
            rx_ready_reg <= 1'b1;
        end
    end
    assign port_enable  = port_en_reg;
    assign force_active = force_reg;
    assign idle_allow   = idle_reg;
    assign rx_ready     = rx_ready_reg;

    // Bus answer
    wire logic [31:0] status_word = {22'h0, guard_reg, msgcmd_reg, call_reg, carrier_reg,
                                     !lines_reg.ri_n, !lines_reg.dcd_n, !lines_reg.dsr_n,
                                     dtr_on, rts_on};
    wire logic [31:0] rd_word = !mapped    ? UNMAPPED_READ :
                                sel_ctrl   ? {24'h0, ctrl_reg} :
                                sel_status ? status_word : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_reg      <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_reg      <= access;
            avs_readdata <= (access && req.read) ? rd_word : avs_readdata;
        end
    end
    assign avs_waitrequest = !ack_reg;
endmodule

/* host_dte.sv */
// Host terminal model driving the handshake lines into the block
`timescale 1ns/1ns
module host_dte (
    input  wire logic clk,
    input  wire logic rts_on,
    input  wire logic dtr_on,
    input  wire logic drive,
    output logic      rts_n_in,
    output logic      rts_n_driven,
    output logic      dtr_n_in,
    output logic      dtr_n_driven
);
    // Ring line is never counted; the host queries instead
    initial begin
        rts_n_in = 1'b1;
        dtr_n_in = 1'b1;
        rts_n_driven = 1'b0;
        dtr_n_driven = 1'b0;
    end
    // Released pins wobble so a stale level never passes for a drive
    always @(posedge clk) begin
        rts_n_driven <= drive;
        dtr_n_driven <= drive;
        rts_n_in     <= drive ? !rts_on : !rts_n_in;
        dtr_n_in     <= drive ? !dtr_on : !dtr_n_in;
    end
endmodule

/* modem_ctl_asserts.sv */
// Concurrent checks on the modem control lines block
`timescale 1ns/1ns
module modem_ctl_asserts
    import modem_ctl_pkg::*;
#(
    parameter int unsigned RING_CNT = RING_CYCLES
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        rts_n_in,
    input wire logic        rts_n_driven,
    input wire logic        dtr_n_in,
    input wire logic        dtr_n_driven,
    input wire logic        dsr_n,
    input wire logic        dcd_n,
    input wire logic        ri_n,
    input wire logic        tx_allow,
    input wire logic        port_enable,
    input wire logic        force_active,
    input wire logic        idle_allow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [7:0]  ctrl_reg;
    logic [31:0] ri_left;
    logic [3:0]  on_cnt;
    logic [3:0]  off_cnt;
    wire wr_ok  = avs_write && !avs_waitrequest;
    wire ev_wr  = wr_ok && avs_address == 8'h08;
    wire rts_on = rts_n_driven && !rts_n_in;
    wire dtr_on = dtr_n_driven && !dtr_n_in;
    wire ps3    = ctrl_reg[5:4] == PSAVE_DTR;
    wire pwr_md = ps3 || (ctrl_reg[5:4] == PSAVE_RTS && !ctrl_reg[0]);
    wire pl_on  = ps3 ? dtr_on : rts_on;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_reg <= CTRL_RESET;
            ri_left  <= '0;
        end else begin
            if (wr_ok && avs_address == 8'h00) begin
                ctrl_reg <= avs_writedata[7:0];
            end else if (ev_wr && avs_writedata[EV_CALL_UP]) begin
                ctrl_reg[7:6] <= MODE_DATA;
            end
            if (ev_wr && avs_writedata[EV_MSG_BIT] && ctrl_reg[3]) begin
                ri_left <= RING_CNT;
            end else if (ri_left != 0) begin
                ri_left <= ri_left - 1;
            end
        end
    end
    // A wake is expected only after the line was seen OFF here
    always_ff @(posedge clk) begin
        if (!reset_n || !pwr_md) begin
            on_cnt  <= '0;
            off_cnt <= '0;
        end else begin
            off_cnt <= pl_on ? '0 : off_cnt + 4'(off_cnt != 4'hf);
            on_cnt  <= !pl_on ? '0 : (on_cnt != 0 || off_cnt != 0) ? on_cnt + 4'(on_cnt != 4'hf) : '0;
        end
    end
    AST_DSR_TRACK:
    assert property (($stable(ctrl_reg)) [*3] ##0 ctrl_reg[1] |-> dsr_n == (ctrl_reg[7:6] != MODE_DATA))
        else $error("dsr does not follow data mode");
    AST_DSR_ON:
    assert property ((!ctrl_reg[1]) [*3] |-> !dsr_n) else $error("dsr not held on");
    AST_DCD_ON:
    assert property ((!ctrl_reg[2]) [*3] |-> !dcd_n) else $error("dcd not held on");
    AST_DCD_DIAL:
    assert property (ev_wr && avs_writedata[EV_CALL_UP] && ctrl_reg[2] |-> ##[1:3] !dcd_n)
        else $error("dcd not raised by dial");
    AST_RI_HOLD:
    assert property (ri_left > 1 && ri_left < RING_CNT |-> !ri_n) else $error("ri dropped early");
    AST_TX_PAUSE:
    assert property ((ctrl_reg[0] && !rts_on) [*6] |-> !tx_allow) else $error("tx not paused");
    AST_WAKE:
    assert property (on_cnt == 6 |-> port_enable && force_active && !idle_allow)
        else $error("port not woken");
    AST_SLEEP:
    assert property (off_cnt == 6 |-> !port_enable && idle_allow) else $error("port not asleep");
endmodule

bind modem_ctl modem_ctl_asserts #(.RING_CNT(RING_CNT)) chk (
    .clk, .reset_n, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest,
    .rts_n_in, .rts_n_driven, .dtr_n_in, .dtr_n_driven, .dsr_n, .dcd_n, .ri_n,
    .tx_allow, .port_enable, .force_active, .idle_allow
);

/* tb_modem_ctl.sv */
// Self-checking testbench for the modem control lines block
`timescale 1ns/1ns
module tb_modem_ctl
    import modem_ctl_pkg::*;
;
    localparam int unsigned RING = 20;
    localparam int unsigned WAKE = 10;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, rts_n_in, rts_n_driven, dtr_n_in, dtr_n_driven;
    logic        dsr_n, dcd_n, ri_n, tx_allow, port_enable, force_active, idle_allow, rx_ready;
    logic        tx_char_done = 1'b0;
    logic        rts_on = 1'b0;
    logic        dtr_on = 1'b0;
    logic        drive = 1'b0;
    logic [31:0] q;
    int          failures = 0;
    int          num_checks = 0;
    always #20 clk = !clk;
    modem_ctl #(.WAKE_CNT(WAKE), .RING_CNT(RING)) uut (
        .clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .rts_n_in, .rts_n_driven, .dtr_n_in,
        .dtr_n_driven, .dsr_n, .dcd_n, .ri_n, .tx_char_done, .tx_allow,
        .port_enable, .force_active, .idle_allow, .rx_ready
    );
    host_dte host (.clk, .rts_on, .dtr_on, .drive, .rts_n_in, .rts_n_driven, .dtr_n_in,
        .dtr_n_driven);
    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until waitrequest is sampled low, released after
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n == 100) failures++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        check("dsr dcd ri", 3'b111, {dsr_n, dcd_n, ri_n});
        wr(8'h0c, 32'hff);
        bus(1'b0, 8'h0c, '0);
        check("unmapped", UNMAPPED_READ, q);
        bus(1'b0, 8'h00, '0);
        check("ctrl", 32'h0f, q);
        $display("test reset done");
        // Columns: driven, rts on, expected tx_allow
        for (int i = 0; i < 4; i++) begin
            drive  <= 4'b0111 >> i;
            rts_on <= 4'b1101 >> i;
            repeat (6) @(posedge clk);
            check("tx_allow", (4'b0101 >> i) & 4'h1, tx_allow);
        end
        tx_char_done <= 1'b1;
        repeat (3) @(posedge clk);
        tx_char_done <= 1'b0;
        bus(1'b0, 8'h04, '0);
        check("guard count", 32'(CHAR_GUARD), {30'h0, q[9:8]});
        $display("test flow done");
        wr(8'h08, 32'h1 << EV_CARR_ON);
        check("dcd carrier", 1'b0, dcd_n);
        wr(8'h08, 32'h1 << EV_CARR_OFF);
        check("dcd no carrier", 1'b1, dcd_n);
        wr(8'h08, 32'h1 << EV_CALL_UP);
        check("dsr dcd dial", 2'b00, {dsr_n, dcd_n});
        wr(8'h00, 32'hcf);
        check("dsr dcd online", 2'b10, {dsr_n, dcd_n});
        wr(8'h08, 32'h1 << EV_MSGCMD_BEG);
        wr(8'h08, 32'h1 << EV_CALL_DOWN);
        check("dcd held", 1'b0, dcd_n);
        wr(8'h08, 32'h1 << EV_MSGCMD_END);
        check("dcd released", 1'b1, dcd_n);
        $display("test call done");
        wr(8'h00, 32'h08);
        check("dsr dcd fixed", 2'b00, {dsr_n, dcd_n});
        wr(8'h08, 32'h1 << EV_MSG_BIT);
        check("ri on", 1'b0, ri_n);
        repeat (8) @(posedge clk);
        wr(8'h08, 32'h1 << EV_MSG_BIT);
        repeat (12) @(posedge clk);
        check("ri retrigger", 1'b0, ri_n);
        repeat (8) @(posedge clk);
        check("ri off", 1'b1, ri_n);
        wr(8'h00, 32'h00);
        wr(8'h08, 32'h1 << EV_MSG_BIT);
        check("ri disabled", 1'b1, ri_n);
        $display("test ring done");
        // Setting 2 then 3; the other line is left OFF
        for (int i = 0; i < 2; i++) begin
            drive <= 1'b0;
            wr(8'h00, i ? 32'h30 : 32'h20);
            repeat (6) @(posedge clk);
            check("port asleep", 2'b01, {port_enable, idle_allow});
            drive  <= 1'b1;
            rts_on <= (i == 0);
            dtr_on <= (i == 1);
            repeat (6) @(posedge clk);
            check("port woken", 4'b1100, {port_enable, force_active, idle_allow, rx_ready});
            repeat (WAKE + 4) @(posedge clk);
            check("rx ready", 1'b1, rx_ready);
            rts_on <= 1'b0;
            dtr_on <= 1'b0;
        end
        $display("test power done");
        close_out();
    end
endmodule
